// ==== include/gmf_pkg.sv ====
// Constants shared by the global multicast filter block
// What this block does
// - Command code 0x12 turns on global multicast filtering with protocol filters
// - After enabling, multicast frames pass only on an enabled address match, a forwarded protocol class or broadcast
// - Enable packet: header 0-15, settings word 16-19, checksum 20-23, pad 24-45
// - Supported protocol filters are reported through a capability field
// - Unsupported settings bits are treated as reserved and ignored
// - Command exists only when the channel can accept all multicast addresses
// - Enabled table entries and forwarded classes are accepted; other multicasts except broadcast are rejected
// - Settings bit one forwards its frame class, zero filters it out
// - Bit 0: all-nodes MAC, IPv6, next header 58, ICMPv6 type 136
// - Bit 1: all-nodes MAC, IPv6, next header 58, ICMPv6 type 134
// - Bit 2: DHCPv6 relay/server MAC, IPv6, UDP 17, destination port 547
// - Each protocol filter is optional and its absence shows in the capabilities
// - Enable and disable commands with good checksum and at least 24 bytes always get a response
package gmf_pkg;
    // ------------------------------------------------------------
    // Command packets
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ENABLE = 8'h12;
    localparam logic [7:0] CMD_DISABLE = 8'h13;
    localparam logic [7:0] RSP_TYPE_FLAG = 8'h80;
    localparam logic [6:0] CMD_TYPE_BYTE = 7'h04;
    localparam logic [6:0] CMD_SET_FIRST = 7'h10;
    localparam logic [6:0] CMD_SET_LAST = 7'h13;
    localparam logic [6:0] CMD_MIN_LAST = 7'h17;
    localparam logic [15:0] RSP_OK = 16'h0000;
    localparam logic [15:0] RSP_UNSUPPORTED = 16'h0001;
    localparam logic [15:0] RSN_NONE = 16'h0000;
    localparam logic [15:0] RSN_UNKNOWN_CMD = 16'h7fff;
    // ------------------------------------------------------------
    // Frame fields
    // ------------------------------------------------------------
    localparam logic [6:0] FB_DMAC_END = 7'h06;
    localparam logic [6:0] FB_ETYPE_HI = 7'h0c;
    localparam logic [6:0] FB_ETYPE_LO = 7'h0d;
    localparam logic [6:0] FB_NEXT_HDR = 7'h14;
    localparam logic [6:0] FB_ICMP_TYPE = 7'h36;
    localparam logic [6:0] FB_DPORT_HI = 7'h38;
    localparam logic [6:0] FB_DPORT_LO = 7'h39;
    localparam logic [47:0] MAC_ALL_NODES = 48'h3333_0000_0001;
    localparam logic [47:0] MAC_DHCP_RELAY = 48'h3333_0001_0002;
    localparam logic [47:0] MAC_DHCP_SERVER = 48'h3333_0001_0003;
    localparam logic [15:0] ETYPE_IPV6 = 16'h86dd;
    localparam logic [7:0] NH_ICMPV6 = 8'h3a;
    localparam logic [7:0] NH_UDP = 8'h11;
    localparam logic [7:0] ICMP_NEIGH_ADV = 8'h88;
    localparam logic [7:0] ICMP_ROUTER_ADV = 8'h86;
    localparam logic [15:0] PORT_DHCP_SERVER = 16'h0223;
    localparam int BIT_NEIGH_ADV = 0;
    localparam int BIT_ROUTER_ADV = 1;
    localparam int BIT_DHCP_SERVER = 2;
    localparam int MCAST_BIT = 40;
    localparam logic [2:0] CAP_DEFAULT = 3'h7;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_SETTINGS = 8'h04;
    localparam logic [7:0] REG_CAPS = 8'h08;
    localparam logic [7:0] REG_PASS_CNT = 8'h0c;
    localparam logic [7:0] REG_DROP_CNT = 8'h10;
    localparam logic [7:0] REG_TABLE_BASE = 8'h20;
    localparam logic [7:0] REG_TABLE_STRIDE = 8'h08;
    localparam int TBL_ENABLE_BIT = 31;
    localparam int STATUS_ACTIVE_BIT = 0;
    localparam int STATUS_FULL_BIT = 1;
endpackage

// ==== rtl/gmf_fifo.sv ====
// Verdict FIFO with registered read data
module gmf_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input wire logic clk, // Block clock
    input wire logic rst, // Asynchronous reset, high
    input wire logic in_valid, // Write request
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word to store
    output logic out_valid, // Output word present
    input wire logic out_ready, // Consumer takes word
    output logic [WIDTH-1:0] out_data // Registered output word
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH)
        begin : g_bad
            $error("gmf_fifo depth must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } gmf_fifo_st_t;

    gmf_fifo_st_t s_r;
    gmf_fifo_st_t s_nxt;
    logic push;
    logic load;

    // Output stage is extra; full is judged on the array alone
    assign in_ready = (s_r.cnt != DEPTH[AW:0]);
    assign out_valid = s_r.ov;
    assign out_data = s_r.od;
    assign push = in_valid && in_ready;
    assign load = (s_r.cnt != '0) && (!s_r.ov || out_ready);

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wr] = in_data;
            s_nxt.wr = s_r.wr + 1'b1;
        end
        if (load)
        begin
            s_nxt.od = s_r.mem[s_r.rd];
            s_nxt.ov = 1'b1;
            s_nxt.rd = s_r.rd + 1'b1;
        end
        else if (out_ready)
        begin
            s_nxt.ov = 1'b0;
        end
        s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule

// ==== rtl/gmf_cmd.sv ====
// Control command capture: packet type and settings word
module gmf_cmd (
    input wire logic clk, // Block clock
    input wire logic rst, // Asynchronous reset, high
    input wire logic in_valid, // Command byte present
    input wire logic in_sof, // First byte of packet
    input wire logic in_eof, // Last byte of packet
    input wire logic [7:0] in_data, // Command byte
    input wire logic in_csum_ok, // Checksum and identifier good, valid with eof
    output logic cmd_done, // One-cycle pulse after a packet ends
    output logic cmd_ok, // Packet long enough and checksum good
    output logic [7:0] cmd_code, // Control packet type
    output logic [31:0] cmd_word // Bytes 16 to 19, first byte high
);
    typedef struct packed {
        logic [6:0] cnt;
        logic [7:0] code;
        logic [31:0] word;
        logic done;
        logic ok;
    } gmf_cmd_st_t;

    gmf_cmd_st_t s_r;
    gmf_cmd_st_t s_nxt;
    logic [6:0] idx;

    assign cmd_done = s_r.done;
    assign cmd_ok = s_r.ok;
    assign cmd_code = s_r.code;
    assign cmd_word = s_r.word;
    assign idx = in_sof ? 7'h00 : s_r.cnt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (in_valid)
        begin
            if (idx != 7'h7f)
            begin
                s_nxt.cnt = idx + 7'h01;
            end
            if (idx == gmf_pkg::CMD_TYPE_BYTE)
            begin
                s_nxt.code = in_data;
            end
            if (idx >= gmf_pkg::CMD_SET_FIRST && idx <= gmf_pkg::CMD_SET_LAST)
            begin
                s_nxt.word = {s_r.word[23:0], in_data};
            end
            if (in_eof)
            begin
                s_nxt.done = 1'b1;
                // Truncated packet cannot carry a checksum after the word
                s_nxt.ok = in_csum_ok && (idx >= gmf_pkg::CMD_MIN_LAST);
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule

// ==== rtl/gmf_top.sv ====
// Global multicast filter: commands, address table, frame verdicts
module gmf_top #(
    parameter int NUM_ENTRIES = 4,
    parameter bit ACCEPT_ALL_MCAST = 1'b1,
    parameter logic [2:0] CAPS = gmf_pkg::CAP_DEFAULT,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic REF_CLK, // Block clock, 20 MHz
    input wire logic RESET, // Asynchronous reset, high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic PREADY, // APB ready
    output logic [31:0] PRDATA, // APB read data
    output logic PSLVERR, // APB error on unmapped address
    input wire logic CMD_VALID, // Command byte present
    input wire logic CMD_SOF, // First command byte
    input wire logic CMD_EOF, // Last command byte
    input wire logic [7:0] CMD_DATA, // Command byte
    input wire logic CMD_CSUM_OK, // Checksum and identifier good
    output logic RSP_VALID, // Response pulse
    output logic [7:0] RSP_TYPE, // Response packet type
    output logic [15:0] RSP_CODE, // Response code
    output logic [15:0] RSP_REASON, // Reason code
    input wire logic RX_VALID, // Frame byte present
    output logic RX_READY, // Frame byte taken
    input wire logic RX_SOF, // First frame byte
    input wire logic RX_EOF, // Last frame byte
    input wire logic [7:0] RX_DATA, // Frame byte
    output logic VERDICT_VALID, // Verdict present
    input wire logic VERDICT_READY, // Verdict consumer ready
    output logic VERDICT_PASS, // Frame goes to management side
    output logic VERDICT_HIT, // Destination matched an enabled entry
    output logic [2:0] VERDICT_CLASS // Protocol filters that forwarded it
);
    localparam int VW = 5;

    generate
        if (NUM_ENTRIES < 1 || NUM_ENTRIES > 8)
        begin : g_bad
            $error("gmf_top supports 1 to 8 table entries");
        end
    endgenerate

    typedef struct packed {
        logic en;
        logic [31:0] settings;
        logic [6:0] cnt;
        logic [47:0] dmac;
        logic [15:0] etype;
        logic [7:0] nh;
        logic [7:0] icmp;
        logic [15:0] dport;
        logic eval;
        logic rsp_valid;
        logic [7:0] rsp_type;
        logic [15:0] rsp_code;
        logic [15:0] rsp_reason;
        logic [31:0] prdata;
        logic [31:0] pass_cnt;
        logic [31:0] drop_cnt;
        logic [NUM_ENTRIES-1:0][47:0] tbl_mac;
        logic [NUM_ENTRIES-1:0] tbl_en;
    } gmf_top_st_t;

    gmf_top_st_t s_r;
    gmf_top_st_t s_nxt;
    logic cmd_done;
    logic cmd_ok;
    logic [7:0] cmd_code;
    logic [31:0] cmd_word;
    logic fifo_in_ready;
    logic [VW-1:0] fifo_out;
    logic [2:0] cls;
    logic hit;
    logic pass;
    logic [6:0] idx;
    logic take;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Table slot of an address: -1 when outside the table window
    function automatic int slot_of(input logic [7:0] a);
        logic [7:0] off;
        off = a - gmf_pkg::REG_TABLE_BASE;
        if (a < gmf_pkg::REG_TABLE_BASE || int'(off[7:3]) >= NUM_ENTRIES || a[1:0] != 2'h0)
        begin
            return -1;
        end
        return int'(off[7:3]);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == gmf_pkg::REG_STATUS) || (a == gmf_pkg::REG_SETTINGS) ||
            (a == gmf_pkg::REG_CAPS) || (a == gmf_pkg::REG_PASS_CNT) ||
            (a == gmf_pkg::REG_DROP_CNT) || (slot_of(a) >= 0);
    endfunction

    // ------------------------------------------------------------
    // Command capture and verdict buffer
    // ------------------------------------------------------------
    gmf_cmd u_cmd (
        .clk(REF_CLK),
        .rst(RESET),
        .in_valid(CMD_VALID),
        .in_sof(CMD_SOF),
        .in_eof(CMD_EOF),
        .in_data(CMD_DATA),
        .in_csum_ok(CMD_CSUM_OK),
        .cmd_done(cmd_done),
        .cmd_ok(cmd_ok),
        .cmd_code(cmd_code),
        .cmd_word(cmd_word)
    );

    gmf_fifo #(
        .WIDTH(VW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .rst(RESET),
        .in_valid(s_r.eval),
        .in_ready(fifo_in_ready),
        .in_data({pass, hit, cls}),
        .out_valid(VERDICT_VALID),
        .out_ready(VERDICT_READY),
        .out_data(fifo_out)
    );

    assign VERDICT_PASS = fifo_out[4];
    assign VERDICT_HIT = fifo_out[3];
    assign VERDICT_CLASS = fifo_out[2:0];

    // Stall during evaluation so one verdict slot is always free
    assign RX_READY = fifo_in_ready && !s_r.eval;
    assign take = RX_VALID && RX_READY;
    assign idx = RX_SOF ? 7'h00 : s_r.cnt;

    assign PREADY = 1'b1;
    assign PRDATA = s_r.prdata;
    assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
    assign RSP_VALID = s_r.rsp_valid;
    assign RSP_TYPE = s_r.rsp_type;
    assign RSP_CODE = s_r.rsp_code;
    assign RSP_REASON = s_r.rsp_reason;

    // ------------------------------------------------------------
    // Frame classification
    // ------------------------------------------------------------
    always_comb
    begin
        logic ip6;
        logic icmp6;
        logic na;
        logic ra;
        logic dhcp;
        logic mcast;
        logic bcast;
        mcast = s_r.dmac[gmf_pkg::MCAST_BIT] && (s_r.cnt >= gmf_pkg::FB_DMAC_END);
        // Broadcast belongs to the broadcast filter, not to this one
        bcast = &s_r.dmac;
        ip6 = (s_r.cnt > gmf_pkg::FB_ETYPE_LO) && (s_r.etype == gmf_pkg::ETYPE_IPV6);
        icmp6 = ip6 && (s_r.cnt > gmf_pkg::FB_ICMP_TYPE) && (s_r.nh == gmf_pkg::NH_ICMPV6);
        na = icmp6 && (s_r.dmac == gmf_pkg::MAC_ALL_NODES) &&
            (s_r.icmp == gmf_pkg::ICMP_NEIGH_ADV);
        ra = icmp6 && (s_r.dmac == gmf_pkg::MAC_ALL_NODES) &&
            (s_r.icmp == gmf_pkg::ICMP_ROUTER_ADV);
        dhcp = ip6 && (s_r.cnt > gmf_pkg::FB_DPORT_LO) && (s_r.nh == gmf_pkg::NH_UDP) &&
            (s_r.dport == gmf_pkg::PORT_DHCP_SERVER) &&
            ((s_r.dmac == gmf_pkg::MAC_DHCP_RELAY) || (s_r.dmac == gmf_pkg::MAC_DHCP_SERVER));
        cls = 3'h0;
        cls[gmf_pkg::BIT_NEIGH_ADV] = na && s_r.settings[gmf_pkg::BIT_NEIGH_ADV];
        cls[gmf_pkg::BIT_ROUTER_ADV] = ra && s_r.settings[gmf_pkg::BIT_ROUTER_ADV];
        cls[gmf_pkg::BIT_DHCP_SERVER] = dhcp && s_r.settings[gmf_pkg::BIT_DHCP_SERVER];
        hit = 1'b0;
        for (int i = 0; i < NUM_ENTRIES; i++)
        begin
            if (s_r.tbl_en[i] && s_r.tbl_mac[i] == s_r.dmac)
            begin
                hit = 1'b1;
            end
        end
        pass = !s_r.en || !mcast || bcast || hit || (|cls);
    end

    // ------------------------------------------------------------
    // State update
    // ------------------------------------------------------------
    always_comb
    begin
        int sl;
        sl = slot_of(PADDR);
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.eval = 1'b0;
        // Field capture; byte count saturates so long frames keep fields
        if (take)
        begin
            if (idx != 7'h7f)
            begin
                s_nxt.cnt = idx + 7'h01;
            end
            if (idx < gmf_pkg::FB_DMAC_END)
            begin
                s_nxt.dmac = {s_r.dmac[39:0], RX_DATA};
            end
            if (idx == gmf_pkg::FB_ETYPE_HI || idx == gmf_pkg::FB_ETYPE_LO)
            begin
                s_nxt.etype = {s_r.etype[7:0], RX_DATA};
            end
            if (idx == gmf_pkg::FB_NEXT_HDR)
            begin
                s_nxt.nh = RX_DATA;
            end
            if (idx == gmf_pkg::FB_ICMP_TYPE)
            begin
                s_nxt.icmp = RX_DATA;
            end
            if (idx == gmf_pkg::FB_DPORT_HI || idx == gmf_pkg::FB_DPORT_LO)
            begin
                s_nxt.dport = {s_r.dport[7:0], RX_DATA};
            end
            s_nxt.eval = RX_EOF;
        end
        if (s_r.eval)
        begin
            if (pass)
            begin
                s_nxt.pass_cnt = s_r.pass_cnt + 32'h0000_0001;
            end
            else
            begin
                s_nxt.drop_cnt = s_r.drop_cnt + 32'h0000_0001;
            end
        end
        // Commands; bad checksum or identifier gets no response
        if (cmd_done && cmd_ok)
        begin
            case (cmd_code)
                gmf_pkg::CMD_ENABLE:
                begin
                    s_nxt.rsp_valid = 1'b1;
                    s_nxt.rsp_type = cmd_code | gmf_pkg::RSP_TYPE_FLAG;
                    if (ACCEPT_ALL_MCAST)
                    begin
                        s_nxt.en = 1'b1;
                        // Unsupported bits dropped as reserved
                        s_nxt.settings = {29'h0, cmd_word[2:0] & CAPS};
                        s_nxt.rsp_code = gmf_pkg::RSP_OK;
                        s_nxt.rsp_reason = gmf_pkg::RSN_NONE;
                    end
                    else
                    begin
                        s_nxt.rsp_code = gmf_pkg::RSP_UNSUPPORTED;
                        s_nxt.rsp_reason = gmf_pkg::RSN_UNKNOWN_CMD;
                    end
                end
                gmf_pkg::CMD_DISABLE:
                begin
                    s_nxt.rsp_valid = 1'b1;
                    s_nxt.rsp_type = cmd_code | gmf_pkg::RSP_TYPE_FLAG;
                    s_nxt.en = 1'b0;
                    s_nxt.rsp_code = ACCEPT_ALL_MCAST ? gmf_pkg::RSP_OK : gmf_pkg::RSP_UNSUPPORTED;
                    s_nxt.rsp_reason = ACCEPT_ALL_MCAST ? gmf_pkg::RSN_NONE : gmf_pkg::RSN_UNKNOWN_CMD;
                end
                default:
                begin
                    s_nxt.rsp_valid = 1'b0;
                end
            endcase
        end
        // APB read data latched in the setup cycle
        if (PSEL && !PENABLE && !PWRITE)
        begin
            s_nxt.prdata = 32'h0000_0000;
            case (PADDR)
                gmf_pkg::REG_STATUS:
                begin
                    s_nxt.prdata[gmf_pkg::STATUS_ACTIVE_BIT] = s_r.en;
                    s_nxt.prdata[gmf_pkg::STATUS_FULL_BIT] = !fifo_in_ready;
                end
                gmf_pkg::REG_SETTINGS:
                begin
                    s_nxt.prdata = s_r.settings;
                end
                gmf_pkg::REG_CAPS:
                begin
                    s_nxt.prdata[2:0] = ACCEPT_ALL_MCAST ? CAPS : 3'h0;
                end
                gmf_pkg::REG_PASS_CNT:
                begin
                    s_nxt.prdata = s_r.pass_cnt;
                end
                gmf_pkg::REG_DROP_CNT:
                begin
                    s_nxt.prdata = s_r.drop_cnt;
                end
                default:
                begin
                    if (sl >= 0)
                    begin
                        s_nxt.prdata = PADDR[2] ?
                            {s_r.tbl_en[sl], 15'h0000, s_r.tbl_mac[sl][47:32]} : s_r.tbl_mac[sl][31:0];
                    end
                end
            endcase
        end
        // Table writes; the controller may add solicited-node entries here
        if (PSEL && PENABLE && PWRITE && sl >= 0)
        begin
            if (PADDR[2])
            begin
                s_nxt.tbl_mac[sl][47:32] = PWDATA[15:0];
                s_nxt.tbl_en[sl] = PWDATA[gmf_pkg::TBL_ENABLE_BIT];
            end
            else
            begin
                s_nxt.tbl_mac[sl][31:0] = PWDATA;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule

// ==== sim/gmf_top_checker.sv ====
// Port assertions for the global multicast filter
module gmf_top_checker (
    input wire logic REF_CLK, // Block clock
    input wire logic RESET, // Reset, high
    input wire logic CMD_VALID, // Command byte
    input wire logic CMD_EOF, // Last command byte
    input wire logic CMD_CSUM_OK, // Checksum good
    input wire logic RSP_VALID, // Response pulse
    input wire logic [7:0] RSP_TYPE, // Response type
    input wire logic RX_VALID, // Frame byte
    input wire logic RX_READY, // Byte taken
    input wire logic RX_EOF, // Last frame byte
    input wire logic VERDICT_VALID, // Verdict present
    input wire logic VERDICT_READY, // Verdict taken
    input wire logic VERDICT_PASS, // Forwarded
    input wire logic VERDICT_HIT, // Table hit
    input wire logic [2:0] VERDICT_CLASS // Forwarding classes
);
    timeunit 1ns / 1ns;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    sequence s_cmd_end;
        CMD_VALID && CMD_EOF;
    endsequence
    sequence s_rx_end;
        RX_VALID && RX_READY && RX_EOF;
    endsequence
    property p_rsp_cause;
        RSP_VALID |-> $past(CMD_VALID && CMD_EOF && CMD_CSUM_OK, 2);
    endproperty
    property p_rsp_pulse;
        RSP_VALID |=> !RSP_VALID;
    endproperty
    property p_bad_csum;
        s_cmd_end ##0 !CMD_CSUM_OK |-> ##2 !RSP_VALID;
    endproperty
    property p_rsp_type;
        RSP_VALID |-> RSP_TYPE == 8'h92 || RSP_TYPE == 8'h93;
    endproperty
    property p_rx_stall;
        s_rx_end |=> !RX_READY;
    endproperty
    property p_hold;
        VERDICT_VALID && !VERDICT_READY |=> VERDICT_VALID && $stable({VERDICT_PASS, VERDICT_HIT, VERDICT_CLASS});
    endproperty
    property p_hit_pass;
        VERDICT_VALID && VERDICT_HIT |-> VERDICT_PASS;
    endproperty
    property p_class_pass;
        VERDICT_VALID && VERDICT_CLASS != 3'h0 |-> VERDICT_PASS;
    endproperty
    a_rsp_cause: assert property (p_rsp_cause) else $error("response without packet end");
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than a cycle");
    a_bad_csum: assert property (p_bad_csum) else $error("response to bad checksum");
    a_rsp_type: assert property (p_rsp_type) else $error("wrong response type");
    a_rx_stall: assert property (p_rx_stall) else $error("no stall after frame end");
    a_hold: assert property (p_hold) else $error("verdict changed while held");
    a_hit_pass: assert property (p_hit_pass) else $error("table hit not passed");
    a_class_pass: assert property (p_class_pass) else $error("class match not passed");
endmodule
bind gmf_top gmf_top_checker gmf_top_checker_inst (.*);

// ==== sim/gmf_mc_model.sv ====
// Management controller model sending command packets
module gmf_mc_model (
    input wire logic clk, // Block clock
    output logic valid, // Command byte present
    output logic sof, // First byte
    output logic eof, // Last byte
    output logic [7:0] data, // Command byte
    output logic csum_ok // Checksum verdict
);
    timeunit 1ns / 1ns;
    initial {valid, sof, eof, data, csum_ok} = 12'h0;
    // Callers of good packets may also set unsupported settings bits
    task automatic send(input logic [7:0] code, input logic [31:0] word, input logic ok);
        for (int i = 0; i < 46; i++)
        begin
            @(posedge clk);
            valid <= 1'b1;
            sof <= i == 0;
            eof <= i == 45;
            csum_ok <= ok;
            data <= i == 4 ? code : (i > 15 && i < 20) ? word[8*(19-i) +: 8] : 8'h00;
        end
        @(posedge clk);
        valid <= 1'b0;
        eof <= 1'b0;
        data <= ~data;
    endtask
endmodule

// ==== sim/gmf_top_tb.sv ====
// Self-checking bench for the global multicast filter
module gmf_top_tb;
    timeunit 1ns / 1ns;
    localparam logic [47:0] MC = 48'h3333_ff00_00fb;
    localparam logic [47:0] AN = 48'h3333_0000_0001;
    logic REF_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR;
    logic [7:0] PADDR = 8'h00, RX_DATA = 8'h00, CMD_DATA, RSP_TYPE;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic CMD_VALID, CMD_SOF, CMD_EOF, CMD_CSUM_OK, RSP_VALID, RX_READY, VERDICT_VALID, VERDICT_PASS, VERDICT_HIT;
    logic RX_VALID = 1'b0, RX_SOF = 1'b0, RX_EOF = 1'b0, VERDICT_READY = 1'b0;
    logic [15:0] RSP_CODE, RSP_REASON;
    logic [2:0] VERDICT_CLASS;
    int mismatches = 0, n_tests = 0;
    gmf_top gmf_top_inst (.*);
    gmf_mc_model gmf_mc_model_inst (.clk(REF_CLK), .valid(CMD_VALID), .sof(CMD_SOF), .eof(CMD_EOF),
        .data(CMD_DATA), .csum_ok(CMD_CSUM_OK));
    always #25 REF_CLK = ~REF_CLK;
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [40:0] exp, input logic [40:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tmo(input logic ok);
        if (!ok)
            chk("timeout", 41'h0, 41'h1);
        if (!ok)
            end_sim();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        for (int w = 0; w < 40 && PREADY !== 1'b1; w++)
            @(posedge REF_CLK);
        tmo(PREADY === 1'b1);
        chk("apb", wr ? {e[32], 32'h0} : e, {PSLVERR, wr ? 32'h0 : PRDATA});
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] code, input logic [31:0] word, input logic ok, input logic [40:0] e);
        gmf_mc_model_inst.send(code, word, ok);
        repeat (2) @(negedge REF_CLK);
        chk("response", e, {RSP_VALID, RSP_TYPE, RSP_CODE, RSP_REASON});
    endtask
    task automatic frame(input logic [47:0] mac, input logic [7:0] nh, input logic [7:0] ty, input logic [15:0] p);
        logic [7:0] b [58] = '{default: 8'h00};
        {b[0], b[1], b[2], b[3], b[4], b[5], b[12], b[13]} = {mac, 16'h86dd};
        {b[20], b[54], b[56], b[57]} = {nh, ty, p};
        @(posedge REF_CLK);
        for (int i = 0; i < 58; i++)
        begin
            RX_VALID <= 1'b1;
            RX_SOF <= i == 0;
            RX_EOF <= i == 57;
            RX_DATA <= b[i];
            @(posedge REF_CLK);
            for (int w = 0; w < 40 && RX_READY !== 1'b1; w++)
                @(posedge REF_CLK);
            tmo(RX_READY === 1'b1);
        end
        RX_VALID <= 1'b0;
        RX_DATA <= ~RX_DATA;
    endtask
    task automatic verdict(input logic [4:0] e);
        for (int w = 0; w < 40 && VERDICT_VALID !== 1'b1; w++)
            @(negedge REF_CLK);
        tmo(VERDICT_VALID === 1'b1);
        chk("verdict", e, {VERDICT_PASS, VERDICT_HIT, VERDICT_CLASS});
        @(posedge REF_CLK);
        VERDICT_READY <= 1'b1;
        @(posedge REF_CLK);
        VERDICT_READY <= 1'b0;
    endtask
    task automatic fv(input logic [47:0] m, input logic [7:0] nh, t, input logic [15:0] p, input logic [4:0] e);
        frame(m, nh, t, p);
        verdict(e);
    endtask
    task automatic t_regs;
        apb(1'b0, 8'h08, 32'h0, 33'h7);
        apb(1'b0, 8'h00, 32'h0, 33'h0);
        apb(1'b0, 8'h1c, 32'h0, 33'h1_0000_0000);
    endtask
    task automatic t_enable;
        cmd(8'h12, 32'hffff_fff9, 1'b1, {9'h192, 32'h0});
        apb(1'b0, 8'h04, 32'h0, 33'h1);
        fv(AN, 8'h3a, 8'h88, 16'h0, 5'h11);
        fv(AN, 8'h3a, 8'h87, 16'h0, 5'h00);
        fv(AN, 8'h3a, 8'h86, 16'h0, 5'h00);
        fv(MC, 8'h00, 8'h00, 16'h0, 5'h00);
        apb(1'b1, 8'h20, MC[31:0], 33'h0);
        apb(1'b1, 8'h24, {16'h8000, MC[47:32]}, 33'h0);
        fv(MC, 8'h00, 8'h00, 16'h0, 5'h18);
    endtask
    task automatic t_refused;
        cmd(8'h12, 32'h6, 1'b0, {9'h092, 32'h0});
        cmd(8'h14, 32'h6, 1'b1, {9'h092, 32'h0});
        apb(1'b0, 8'h04, 32'h0, 33'h1);
        cmd(8'h12, 32'h6, 1'b1, {9'h192, 32'h0});
        fv(AN, 8'h3a, 8'h86, 16'h0, 5'h12);
        fv(48'h3333_0001_0003, 8'h11, 8'h00, 16'h0223, 5'h14);
        fv(48'h3333_0001_0002, 8'h11, 8'h00, 16'h0222, 5'h00);
        fv(AN, 8'h3a, 8'h88, 16'h0, 5'h00);
    endtask
    task automatic t_fifo;
        repeat (17) frame(MC, 8'h00, 8'h00, 16'h0);
        repeat (3) @(negedge REF_CLK);
        chk("rx_ready", 41'h0, RX_READY);
        apb(1'b0, 8'h00, 32'h0, 33'h3);
        repeat (17) verdict(5'h18);
        apb(1'b0, 8'h00, 32'h0, 33'h1);
    endtask
    task automatic t_disable;
        cmd(8'h13, 32'h0, 1'b1, {9'h193, 32'h0});
        fv(48'h0100_5e00_0001, 8'h00, 8'h00, 16'h0, 5'h10);
        apb(1'b0, 8'h0c, 32'h0, 33'h16);
        apb(1'b0, 8'h10, 32'h0, 33'h5);
    endtask
    initial
    begin
        repeat (12) @(posedge REF_CLK);
        RESET <= 1'b0;
        t_regs();
        t_enable();
        t_refused();
        t_fifo();
        t_disable();
        end_sim();
    end
endmodule
